// ---- pulsewidth_measure_counter.sv ----
// Four-channel pulse-duration measurement counter with register port and scan strobes
// How it works
// - Count ticks from a pulse's leading edge to its opposite trailing edge.
// - Per-channel edge polarity picks high-level or low-level pulse measurement.
// - On latching a result the counter clears at once and re-arms.
// - Each result is latched on completion and held for every scan until replaced.
// - Acquisition start clears all counters; scans read zero until a first pulse.
// - Four tick sizes, 3 up to 2604 clock cycles (24 ns up to 20832 ns), divided from the clock.
// - A width option selects a 16-bit or a 32-bit counter.
// - The counter saturates at 65535 or 4294967295 ticks, never wraps.
// - Gate option: another channel high enables counting; low pauses and holds.
// - Remap option: measure another debounced channel instead of the own input.
// - No averaging: each held value is exactly one pulse.
// - Four channels, each with its own independent readout strobe.
module pulsewidth_measure_counter (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [3:0] chanIn,
   input wire logic [3:0] edgePolarity,
   input wire logic [3:0] scanStrobe,
   output logic [31:0] scanData0,
   output logic [31:0] scanData1,
   output logic [31:0] scanData2,
   output logic [31:0] scanData3,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdData
);
   logic [pwm_measure_pkg::CFG_BITS-1:0] cfg_reg [pwm_measure_pkg::NUM_CHAN];
   logic acqStart;
   logic [3:0] tickEn;
   logic [31:0] held [pwm_measure_pkg::NUM_CHAN];
   logic [3:0] timing;
   logic [31:0] scanOut [pwm_measure_pkg::NUM_CHAN];

   // Decode a byte address into a channel slot of a four-register block
   function automatic logic hitBlock(input logic [7:0] addr, input logic [7:0] base, input int n);
      hitBlock = (addr == base + 8'(4 * n));
   endfunction : hitBlock

   // Writing the start bit begins an acquisition; a one-cycle pulse
   assign acqStart = regWrite && regAddr == pwm_measure_pkg::ADDR_CTRL
                     && regWrData[pwm_measure_pkg::CTRL_START_BIT];

   tick_divider uTicks (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .restart(acqStart),
      .tickEn(tickEn)
   );

   genvar c;
   generate
      for (c = 0; c < pwm_measure_pkg::NUM_CHAN; c++) begin : gChan
         logic [1:0] tickSel;
         logic [1:0] gateSel;
         logic [1:0] srcSel;
         logic srcIdx;
         logic [1:0] srcChan;

         // Per-channel configuration register
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               cfg_reg[c] <= pwm_measure_pkg::CFG_RESET;
            end else if (regWrite && hitBlock(regAddr, pwm_measure_pkg::ADDR_CFG0, c)) begin
               cfg_reg[c] <= regWrData[pwm_measure_pkg::CFG_BITS-1:0];
            end
         end

         assign tickSel = cfg_reg[c][pwm_measure_pkg::CFG_TICK_LSB +: 2];
         assign gateSel = cfg_reg[c][pwm_measure_pkg::CFG_GSEL_LSB +: 2];
         assign srcSel = cfg_reg[c][pwm_measure_pkg::CFG_SSEL_LSB +: 2];
         assign srcIdx = cfg_reg[c][pwm_measure_pkg::CFG_REMAP_BIT];
         // Remapped channels use the source's own debounced level and polarity
         assign srcChan = srcIdx ? srcSel : 2'(c);

         pw_channel uChan (
            .clk_sys(clk_sys),
            .rst_n(rst_n),
            .clearAll(acqStart),
            .tickEn(tickEn[tickSel]),
            .srcLevel(chanIn[srcChan]),
            .polarity(edgePolarity[srcChan]),
            .gateLevel(chanIn[gateSel]),
            .gateEnable(cfg_reg[c][pwm_measure_pkg::CFG_GATE_BIT]),
            .wide32(cfg_reg[c][pwm_measure_pkg::CFG_WIDE_BIT]),
            .heldValue(held[c]),
            .timing(timing[c])
         );

         // Each scan strobe copies its own channel's held value, independent of the rest
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               scanOut[c] <= 32'h00000000;
            end else if (scanStrobe[c]) begin
               scanOut[c] <= held[c];
            end
         end
      end
   endgenerate

   assign scanData0 = scanOut[0];
   assign scanData1 = scanOut[1];
   assign scanData2 = scanOut[2];
   assign scanData3 = scanOut[3];

   // Read data one cycle after the strobe; unmapped and idle cycles read zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         regRdData <= 32'h00000000;
      end else begin
         regRdData <= 32'h00000000;
         if (regRead) begin
            for (int i = 0; i < pwm_measure_pkg::NUM_CHAN; i++) begin
               if (hitBlock(regAddr, pwm_measure_pkg::ADDR_CFG0, i)) begin
                  regRdData <= {23'h000000, cfg_reg[i]};
               end
               if (hitBlock(regAddr, pwm_measure_pkg::ADDR_VAL0, i)) begin
                  regRdData <= held[i];
               end
            end
            if (regAddr == pwm_measure_pkg::ADDR_STAT) begin
               regRdData <= {28'h0000000, timing};
            end
         end
      end
   end
endmodule : pulsewidth_measure_counter

// ---- pwm_measure_pkg.sv ----
// Constants shared by the pulse-duration measurement counter block
package pwm_measure_pkg;
   // Clock rate and the four printed tick sizes in picoseconds
   localparam longint CLK_MHZ = 125;
   localparam longint TICK0_PS = 20830;
   localparam longint TICK1_PS = 208300;
   localparam longint TICK2_PS = 2083000;
   localparam longint TICK3_PS = 20833000;
   localparam longint PS_PER_US = 1000000;
   // Cycles per tick, rounded to the nearest whole cycle: 3, 26, 260 and 2604
   localparam logic [11:0] TICK0_CYC = 12'((TICK0_PS * CLK_MHZ + PS_PER_US / 2) / PS_PER_US);
   localparam logic [11:0] TICK1_CYC = 12'((TICK1_PS * CLK_MHZ + PS_PER_US / 2) / PS_PER_US);
   localparam logic [11:0] TICK2_CYC = 12'((TICK2_PS * CLK_MHZ + PS_PER_US / 2) / PS_PER_US);
   localparam logic [11:0] TICK3_CYC = 12'((TICK3_PS * CLK_MHZ + PS_PER_US / 2) / PS_PER_US);

   localparam int NUM_CHAN = 4;
   localparam logic [31:0] MAX16 = 32'h0000ffff;
   localparam logic [31:0] MAX32 = 32'hffffffff;

   // Register byte addresses
   localparam logic [7:0] ADDR_CFG0 = 8'h00;   // Config of channel n at ADDR_CFG0 + 4*n
   localparam logic [7:0] ADDR_VAL0 = 8'h10;   // Held value of channel n at ADDR_VAL0 + 4*n
   localparam logic [7:0] ADDR_CTRL = 8'h20;
   localparam logic [7:0] ADDR_STAT = 8'h24;

   // Config fields
   localparam int CFG_TICK_LSB = 0;
   localparam int CFG_WIDE_BIT = 2;
   localparam int CFG_GATE_BIT = 3;
   localparam int CFG_REMAP_BIT = 4;
   localparam int CFG_GSEL_LSB = 5;
   localparam int CFG_SSEL_LSB = 7;
   localparam int CFG_BITS = 9;
   localparam logic [8:0] CFG_RESET = 9'h000;
   localparam int CTRL_START_BIT = 0;

   typedef enum logic {ARMED = 1'b0, TIMING = 1'b1} chan_state_t;
endpackage : pwm_measure_pkg

// ---- tick_divider.sv ----
// Divides the system clock into four one-cycle tick enables
module tick_divider (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic restart,
   output logic [3:0] tickEn
);
   localparam logic [11:0] DIVS [4] = '{pwm_measure_pkg::TICK0_CYC, pwm_measure_pkg::TICK1_CYC,
                                        pwm_measure_pkg::TICK2_CYC, pwm_measure_pkg::TICK3_CYC};

   // One free counter per tick size; restart realigns them with acquisition start
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : gDiv
         logic [11:0] divCnt_reg;
         always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
               divCnt_reg <= 12'h000;
            end else if (restart || divCnt_reg == DIVS[g] - 12'h001) begin
               divCnt_reg <= 12'h000;
            end else begin
               divCnt_reg <= divCnt_reg + 12'h001;
            end
         end
         assign tickEn[g] = !restart && (divCnt_reg == DIVS[g] - 12'h001);
      end
   endgenerate
endmodule : tick_divider

// ---- pw_channel.sv ----
// One pulse-duration counter channel with its held result
module pw_channel (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clearAll,
   input wire logic tickEn,
   input wire logic srcLevel,
   input wire logic polarity,
   input wire logic gateLevel,
   input wire logic gateEnable,
   input wire logic wide32,
   output logic [31:0] heldValue,
   output logic timing
);
   pwm_measure_pkg::chan_state_t state_reg;
   logic srcPrev_reg;
   logic [31:0] count_reg;
   logic leadEdge;
   logic trailEdge;
   logic [31:0] countMax;

   // Polarity high: high pulse, leading edge rising; low: low pulse
   assign leadEdge = (srcLevel != srcPrev_reg) && (srcLevel == polarity);
   assign trailEdge = (srcLevel != srcPrev_reg) && (srcLevel != polarity);
   assign countMax = wide32 ? pwm_measure_pkg::MAX32 : pwm_measure_pkg::MAX16;
   assign timing = (state_reg == pwm_measure_pkg::TIMING);

   // Previous level for edge detection
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         srcPrev_reg <= 1'b0;
      end else begin
         srcPrev_reg <= srcLevel;
      end
   end

   // Armed waits for a leading edge, so after an acquisition start the first result is a whole pulse
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= pwm_measure_pkg::ARMED;
      end else if (clearAll) begin
         state_reg <= pwm_measure_pkg::ARMED;
      end else begin
         unique case (state_reg)
            pwm_measure_pkg::ARMED: begin
               if (leadEdge) begin
                  state_reg <= pwm_measure_pkg::TIMING;
               end
            end
            pwm_measure_pkg::TIMING: begin
               if (trailEdge) begin
                  state_reg <= pwm_measure_pkg::ARMED;
               end
            end
         endcase
      end
   end

   // Tick counter: saturates, pauses while the gate is low, cleared on latch
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 32'h00000000;
      end else if (clearAll) begin
         count_reg <= 32'h00000000;
      end else if (timing && trailEdge) begin
         count_reg <= 32'h00000000;
      end else if (timing && tickEn && (!gateEnable || gateLevel) && count_reg < countMax) begin
         count_reg <= count_reg + 32'h00000001;
      end
   end

   // One pulse per result, no averaging; held until the next pulse completes
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         heldValue <= 32'h00000000;
      end else if (clearAll) begin
         heldValue <= 32'h00000000;
      end else if (timing && trailEdge) begin
         heldValue <= count_reg;
      end
   end
endmodule : pw_channel

// ---- pulsewidth_measure_counter_props.sv ----
// Port checker for the pulse-duration counter
module pulsewidth_measure_counter_props (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [3:0] scanStrobe,
   input wire logic [31:0] scanData0,
   input wire logic [7:0] regAddr,
   input wire logic [31:0] regWrData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // Outputs come out of reset at zero
   property p_rst_out; $rose(rst_n) |-> regRdData == 32'h0 && scanData0 == 32'h0; endproperty
   a_rst_out: assert property (p_rst_out) else $error("outputs not zero after reset");
   // A scanned value holds until the next strobe
   property p_scan_hold; !scanStrobe[0] |=> $stable(scanData0); endproperty
   a_scan_hold: assert property (p_scan_hold) else $error("scan value moved");
   // Strobe and register read see one held value
   property p_scan_read; scanStrobe[0] && regRead && regAddr == pwm_measure_pkg::ADDR_VAL0
      |=> regRdData == scanData0; endproperty
   a_scan_read: assert property (p_scan_read) else $error("scan and read differ");
   // Start of acquisition clears the held value
   property p_start_clear; regWrite && regAddr == pwm_measure_pkg::ADDR_CTRL && regWrData[0] ##2 scanStrobe[0]
      |=> scanData0 == 32'h0; endproperty
   a_start_clear: assert property (p_start_clear) else $error("held value not cleared");
   // Start of acquisition drops every timing flag
   property p_start_stat; regWrite && regAddr == pwm_measure_pkg::ADDR_CTRL && regWrData[0]
      ##2 regRead && regAddr == pwm_measure_pkg::ADDR_STAT |=> regRdData == 32'h0; endproperty
   a_start_stat: assert property (p_start_stat) else $error("status not cleared");
   // Option bits of any channel read back as written, upper bits zero
   property p_cfg_back; regWrite && regAddr < pwm_measure_pkg::ADDR_VAL0 && regAddr[1:0] == 2'b00
      ##2 regRead && regAddr == $past(regAddr, 2)
      |=> regRdData == {23'h000000, $past(regWrData[8:0], 3)}; endproperty
   a_cfg_back: assert property (p_cfg_back) else $error("config readback wrong");
   // Read data stand one cycle only
   property p_rd_idle; !regRead |=> regRdData == 32'h0; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
   // Status shows four channels only
   property p_stat_rd; regRead && regAddr == pwm_measure_pkg::ADDR_STAT |=> regRdData[31:4] == 28'h0; endproperty
   a_stat_rd: assert property (p_stat_rd) else $error("status upper bits set");
endmodule : pulsewidth_measure_counter_props
bind pulsewidth_measure_counter pulsewidth_measure_counter_props i_props (.clk_sys(clk_sys), .rst_n(rst_n),
   .scanStrobe(scanStrobe), .scanData0(scanData0), .regAddr(regAddr), .regWrData(regWrData),
   .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData));

// ---- pulse_source_model.sv ----
// Debounced input source: level pulses away from each channel's idle level
module pulse_source_model (
   input wire logic clk_sys,
   input wire logic [3:0] pulseGo,
   input wire logic [15:0] pulseLen,
   input wire logic [3:0] idleLevel,
   output logic [3:0] chanIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] left [4] = '{default: 16'h0};
   // One counter per channel, so a gate pulse may overlap a measured one
   always @(posedge clk_sys) begin
      for (int i = 0; i < 4; i++) begin
         if (pulseGo[i]) left[i] <= pulseLen;
         else if (left[i] != 16'h0) left[i] <= left[i] - 16'h1;
      end
   end
   // Level is away from idle while the counter runs
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         chanIn[i] = (left[i] != 16'h0) ? ~idleLevel[i] : idleLevel[i];
      end
   end
endmodule : pulse_source_model

// ---- pulsewidth_measure_counter_tb.sv ----
// Self-checking bench for the pulse-duration counter
module pulsewidth_measure_counter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [31:0] lo; logic [31:0] hi;} exp_t;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] edgePolarity = 4'hd;
   logic [3:0] scanStrobe = 4'h0;
   logic [7:0] regAddr = 8'h00;
   logic [31:0] regWrData = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic rdPend = 1'b0;
   logic [3:0] pulseGo = 4'h0;
   logic [15:0] pulseLen = 16'h0;
   logic [3:0] chanIn;
   logic [31:0] regRdData;
   logic [31:0] scanData [4];
   logic [3:0] scanPend = 4'h0;
   exp_t expQ[$];
   exp_t scanQ[$];
   int n_mismatch = 0;
   int samples_checked = 0;
   int cycles = 0;
   int divs[4] = '{3, 26, 260, 2604};
   int len;
   pulsewidth_measure_counter i_pulsewidth_measure_counter (.clk_sys(clk_sys), .rst_n(rst_n), .chanIn(chanIn),
      .edgePolarity(edgePolarity), .scanStrobe(scanStrobe), .scanData0(scanData[0]), .scanData1(scanData[1]),
      .scanData2(scanData[2]), .scanData3(scanData[3]), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead),
      .regRdData(regRdData));
   pulse_source_model i_pulse_source_model (.clk_sys(clk_sys), .pulseGo(pulseGo), .pulseLen(pulseLen),
      .idleLevel(~edgePolarity), .chanIn(chanIn));
   always #4 clk_sys = ~clk_sys;
   task automatic tally_and_finish();
      $display("checked %0d, mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // Hang guard: the tests need at most about 12000 cycles
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 60000) begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // A tick phase is unknown, so a result is taken from a window
   task automatic check_rd(input logic [31:0] got);
      exp_t e;
      e = expQ.pop_front();
      samples_checked++;
      if (((got >= e.lo) && (got <= e.hi)) !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t read %h outside %h..%h", $time, got, e.lo, e.hi);
      end
   endtask : check_rd
   // Scan values of all channels are compared from one shared queue, oldest note first
   task automatic check_scan(input int ch, input logic [31:0] got);
      exp_t e;
      e = scanQ.pop_front();
      samples_checked++;
      if (((got >= e.lo) && (got <= e.hi)) !== 1'b1) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t scan %0d %h outside %h..%h", $time, ch, got, e.lo, e.hi);
      end
   endtask : check_scan
   // Read data and scan values stand in the cycle after their strobe
   always @(posedge clk_sys) begin
      if (rdPend) check_rd(regRdData);
      for (int i = 0; i < 4; i++) begin
         if (scanPend[i]) check_scan(i, scanData[i]);
      end
      rdPend <= regRead;
      scanPend <= scanStrobe;
   end
   task automatic rd(input logic [7:0] a, input int lo, input int hi, input logic s = 1'b0);
      @(posedge clk_sys);
      regAddr <= a;
      regRead <= 1'b1;
      scanStrobe[0] <= s;
      expQ.push_back('{32'(lo), 32'(hi)});
      if (s) scanQ.push_back('{32'(lo), 32'(hi)});
      @(posedge clk_sys);
      regRead <= 1'b0;
      scanStrobe[0] <= 1'b0;
   endtask : rd
   // One strobe on one channel; its value is checked on that channel's scan port, other ports are not checked
   task automatic scan(input int ch, input int lo, input int hi);
      @(posedge clk_sys);
      scanStrobe[ch] <= 1'b1;
      scanQ.push_back('{32'(lo), 32'(hi)});
      @(posedge clk_sys);
      scanStrobe[ch] <= 1'b0;
   endtask : scan
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk_sys);
      regWrite <= 1'b0;
   endtask : wr
   // Waits past the trailing edge so the result is latched
   task automatic pulse(input logic [3:0] ch, input int n);
      @(posedge clk_sys);
      pulseLen <= 16'(n);
      pulseGo <= ch;
      @(posedge clk_sys);
      pulseGo <= 4'h0;
      repeat (n + 2) @(posedge clk_sys);
   endtask : pulse
   initial begin
      void'($urandom(25));
      repeat (12) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int a = 0; a < 40; a += 4) rd(8'(a), 0, 0);
      rd(8'h30, 0, 0);
      $display("test reset done");
      for (int t = 0; t < 4; t++) begin
         wr(8'h00, 32'(t));
         len = divs[t] * (2 + $urandom % 3);
         pulse(4'h1, len);
         rd(8'h10, len / divs[t] - 1, len / divs[t] + 1);
      end
      $display("test tick sizes done");
      wr(8'h00, 32'h4);
      pulse(4'h1, 12);
      rd(8'h10, 3, 5, 1'b1);
      rd(8'h10, 3, 5);
      wr(8'h04, 32'h4);
      pulse(4'h2, 45);
      rd(8'h14, 14, 16);
      scan(1, 14, 16);
      $display("test replace and polarity done");
      wr(8'h08, 32'h68);
      pulse(4'h4, 60);
      rd(8'h18, 0, 0);
      pulse(4'hc, 60);
      rd(8'h18, 19, 21);
      scan(2, 19, 21);
      wr(8'h0c, 32'h10);
      rd(8'h0c, 16, 16);
      pulse(4'h1, 30);
      rd(8'h1c, 9, 11);
      scan(3, 9, 11);
      $display("test gate and remap done");
      wr(8'h20, 32'h1);
      rd(8'h24, 0, 0, 1'b1);
      rd(8'h10, 0, 0, 1'b1);
      $display("test restart done");
      tally_and_finish();
   end
endmodule : pulsewidth_measure_counter_tb
